// >>> src/ascr_core.sv
// Asynchronous serial interface with its two control registers on an Avalon-MM slave
//
// Chosen here: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps
`include "ascr_defs.svh"

module ascr_core (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        clk_en,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        rx_in,
    output logic             tx_out,
    output logic             tx_oe,
    output logic             serial_irq
);

    logic                    rst_meta_reg;
    logic                    rst_n_reg;
    logic                    rx_meta_reg;
    logic                    rx_sync_reg;
    logic                    rx_prev_reg;
    logic                    ack_reg;
    logic [31:0]             rdata_reg;
    logic [7:0]              ctrl_one;
    logic [7:0]              ctrl_two;
    logic [15:0]             baud_reg;
    logic [7:0]              tdr_reg;
    logic [8:0]              rdr_reg;
    logic                    stat_seen_reg;
    logic                    tx_holding_empty_reg;
    logic                    tc_reg;
    logic                    rx_full_flag_reg;
    logic                    idle_reg;
    logic                    ovr_reg;
    logic                    pe_reg;
    ascr_pkg::ascr_tx_state_e tx_state_reg;
    ascr_pkg::ascr_kind_e    tx_kind_reg;
    logic [10:0]             tx_frame_reg;
    logic [3:0]              tx_bit_reg;
    logic [3:0]              tx_len_reg;
    logic [15:0]             tx_cnt_reg;
    logic                    te_prev_reg;
    logic                    sbk_prev_reg;
    logic                    te_drop_reg;
    logic                    pre_req_reg;
    logic                    brk_req_reg;
    logic                    tx_ever_reg;
    ascr_pkg::ascr_rx_state_e rx_state_reg;
    logic [15:0]             rx_cnt_reg;
    logic [3:0]              rx_bit_reg;
    logic [8:0]              rx_sh_reg;
    logic                    rx_m_reg;
    logic                    rx_pce_reg;
    logic                    rx_ps_reg;
    logic [3:0]              quiet_reg;
    logic                    idle_arm_reg;

    logic                    wr_go;
    logic                    rd_go;
    logic                    rd_data_seq;
    logic                    wr_data_seq;
    logic [31:0]             rd_mux;
    logic                    tx_tick;
    logic                    tx_last;
    logic                    tx_start;
    logic                    tx_end;
    logic                    rx_tick;
    logic                    rx_half;
    logic                    word_done;
    logic [8:0]              word9;
    logic                    word_msb;
    logic                    word_take;
    logic                    parity_bad;
    logic                    quiet_hit;
    logic                    mute_clr;
    logic [8:0]              tx_data9;
    logic [10:0]             tx_data_frame;

    function automatic logic par_calc(input logic [8:0] d, input logic nine);
        par_calc = nine ? ^d[7:0] : ^d[6:0];
    endfunction

    function automatic logic bit_done(input logic [15:0] cnt, input logic [15:0] div);
        bit_done = (cnt >= div - 16'h0001);
    endfunction

    function automatic logic [3:0] frame_len(input logic nine);
        frame_len = nine ? `ASCR_LEN_NINE : `ASCR_LEN_EIGHT;
    endfunction

    // Reset release is synchronised so no flop leaves reset on a partial edge
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end
        else if (clk_en)
        begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
            rx_prev_reg <= 1'b1;
        end
        else if (clk_en)
        begin
            rx_meta_reg <= rx_in;
            rx_sync_reg <= rx_meta_reg;
            rx_prev_reg <= rx_sync_reg;
        end
    end

    // Bus: one wait cycle per access, read data fetched during the wait
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign wr_go           = avs_write & ack_reg;
    assign rd_go           = avs_read & ack_reg;
    assign rd_data_seq     = rd_go & (avs_address == `ASCR_OFF_DATA) & stat_seen_reg;
    assign wr_data_seq     = wr_go & (avs_address == `ASCR_OFF_DATA) & stat_seen_reg;
    assign avs_readdata    = rdata_reg;

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (avs_address)
            `ASCR_OFF_CTRL_ONE: rd_mux = {24'h00_0000, ctrl_one};
            `ASCR_OFF_CTRL_TWO: rd_mux = {24'h00_0000, ctrl_two};
            `ASCR_OFF_STATUS:   rd_mux = {24'h00_0000, tx_holding_empty_reg, tc_reg, rx_full_flag_reg, idle_reg, ovr_reg, 2'b00, pe_reg};
            `ASCR_OFF_DATA:     rd_mux = {24'h00_0000, rdr_reg[7:0]};
            `ASCR_OFF_BAUD:     rd_mux = {16'h0000, baud_reg};
            default:            rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            ack_reg       <= 1'b0;
            rdata_reg     <= 32'h0000_0000;
            stat_seen_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
            if (avs_read & ~ack_reg)
                rdata_reg <= rd_mux;
            if (rd_go & (avs_address == `ASCR_OFF_STATUS))
                stat_seen_reg <= 1'b1;
            else if (rd_data_seq | wr_data_seq)
                stat_seen_reg <= 1'b0;
        end
    end

    // Control registers; bit 7 of ctrl_one is filled by the receiver only
    always_ff @(posedge sys_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            ctrl_one <= `ASCR_CTRL_ONE_RST;
            ctrl_two <= `ASCR_CTRL_TWO_RST;
            baud_reg <= `ASCR_BAUD_RST;
            tdr_reg  <= 8'h00;
        end
        else if (clk_en)
        begin
            if (wr_go & (avs_address == `ASCR_OFF_CTRL_ONE))
                ctrl_one[6:0] <= avs_writedata[6:0];
            if (word_take & ~rx_full_flag_reg & rx_m_reg)
                ctrl_one[`ASCR_C1_RX9] <= word9[8];
            // A software write to ctrl_two outranks the hardware wake-up clear
            if (wr_go & (avs_address == `ASCR_OFF_CTRL_TWO))
                ctrl_two <= avs_writedata[7:0];
            else if (mute_clr)
                ctrl_two[`ASCR_C2_RWU] <= 1'b0;
            if (wr_go & (avs_address == `ASCR_OFF_BAUD) & (avs_writedata[15:0] != 16'h0000))
                baud_reg <= avs_writedata[15:0];
            if (wr_go & (avs_address == `ASCR_OFF_DATA))
                tdr_reg <= avs_writedata[7:0];
        end
    end

    // Transmitter
    assign tx_tick  = bit_done(tx_cnt_reg, baud_reg);
    assign tx_last  = tx_tick & (tx_bit_reg == tx_len_reg - 4'h1);
    assign tx_end   = (tx_state_reg == ascr_pkg::ASCR_TX_SHIFT) & tx_last;
    assign tx_start = (tx_state_reg == ascr_pkg::ASCR_TX_IDLE) & ctrl_two[`ASCR_C2_TE] & ~ctrl_one[`ASCR_C1_OFF]
                      & te_prev_reg & (brk_req_reg | pre_req_reg | ~tx_holding_empty_reg);

    always_comb
    begin
        tx_data9 = {ctrl_one[`ASCR_C1_TX9], tdr_reg};
        if (ctrl_one[`ASCR_C1_PCE])
        begin
            if (ctrl_one[`ASCR_C1_M])
                tx_data9[8] = par_calc(tx_data9, 1'b1) ^ ctrl_one[`ASCR_C1_PS];
            else
                tx_data9[7] = par_calc(tx_data9, 1'b0) ^ ctrl_one[`ASCR_C1_PS];
        end
        if (ctrl_one[`ASCR_C1_M])
            tx_data_frame = {1'b1, tx_data9, 1'b0};
        else
            tx_data_frame = {2'b11, tx_data9[7:0], 1'b0};
    end

    always_ff @(posedge sys_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            tx_state_reg <= ascr_pkg::ASCR_TX_IDLE;
            tx_kind_reg  <= ascr_pkg::ASCR_KIND_DATA;
            tx_frame_reg <= 11'h7FF;
            tx_bit_reg   <= 4'h0;
            tx_len_reg   <= `ASCR_LEN_EIGHT;
            tx_cnt_reg   <= 16'h0000;
        end
        else if (clk_en)
        begin
            unique case (tx_state_reg)
                ascr_pkg::ASCR_TX_IDLE:
                begin
                    tx_cnt_reg <= 16'h0000;
                    tx_bit_reg <= 4'h0;
                    if (ctrl_two[`ASCR_C2_TE] & ~te_prev_reg)
                        tx_state_reg <= ascr_pkg::ASCR_TX_WAIT;
                    else if (tx_start)
                    begin
                        // Format latched per frame so mode changes apply from the next word
                        tx_state_reg <= ascr_pkg::ASCR_TX_SHIFT;
                        tx_len_reg   <= frame_len(ctrl_one[`ASCR_C1_M]);
                        if (brk_req_reg)
                        begin
                            tx_kind_reg  <= ascr_pkg::ASCR_KIND_BREAK;
                            tx_frame_reg <= 11'h000;
                        end
                        else if (pre_req_reg)
                        begin
                            tx_kind_reg  <= ascr_pkg::ASCR_KIND_IDLE;
                            tx_frame_reg <= 11'h7FF;
                        end
                        else
                        begin
                            tx_kind_reg  <= ascr_pkg::ASCR_KIND_DATA;
                            tx_frame_reg <= tx_data_frame;
                        end
                    end
                end
                ascr_pkg::ASCR_TX_WAIT:
                begin
                    tx_cnt_reg <= tx_tick ? 16'h0000 : tx_cnt_reg + 16'h0001;
                    if (tx_tick)
                        tx_state_reg <= ascr_pkg::ASCR_TX_IDLE;
                end
                ascr_pkg::ASCR_TX_SHIFT:
                begin
                    tx_cnt_reg <= tx_tick ? 16'h0000 : tx_cnt_reg + 16'h0001;
                    if (tx_tick)
                    begin
                        tx_frame_reg <= {1'b1, tx_frame_reg[10:1]};
                        tx_bit_reg   <= tx_bit_reg + 4'h1;
                    end
                    if (tx_last)
                        tx_state_reg <= ascr_pkg::ASCR_TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            te_prev_reg  <= 1'b0;
            sbk_prev_reg <= 1'b0;
            te_drop_reg  <= 1'b0;
            pre_req_reg  <= 1'b0;
            brk_req_reg  <= 1'b0;
            tx_ever_reg  <= 1'b0;
        end
        else if (clk_en)
        begin
            te_prev_reg  <= ctrl_two[`ASCR_C2_TE];
            sbk_prev_reg <= ctrl_two[`ASCR_C2_SBK];
            if (ctrl_two[`ASCR_C2_TE])
                tx_ever_reg <= 1'b1;
            if (~ctrl_two[`ASCR_C2_TE] & te_prev_reg & (tx_state_reg == ascr_pkg::ASCR_TX_SHIFT))
                te_drop_reg <= 1'b1;
            else if (ctrl_two[`ASCR_C2_TE] & ~te_prev_reg)
                te_drop_reg <= 1'b0;
            if (ctrl_two[`ASCR_C2_TE] & ~te_prev_reg & te_drop_reg)
                pre_req_reg <= 1'b1;
            else if (tx_start & ~brk_req_reg)
                pre_req_reg <= 1'b0;
            if (~ctrl_two[`ASCR_C2_SBK] & sbk_prev_reg)
                brk_req_reg <= 1'b1;
            else if (tx_start)
                brk_req_reg <= 1'b0;
        end
    end

    assign tx_out = tx_frame_reg[0];
    // Pin is handed back when both directions are off or tx_on was never set; serial_off frees it once idle
    assign tx_oe  = tx_ever_reg & (ctrl_two[`ASCR_C2_TE] | ctrl_two[`ASCR_C2_RE])
                    & ~(ctrl_one[`ASCR_C1_OFF] & (tx_state_reg != ascr_pkg::ASCR_TX_SHIFT));

    // Receiver
    assign rx_tick    = bit_done(rx_cnt_reg, baud_reg);
    assign rx_half    = rx_cnt_reg >= {1'b0, baud_reg[15:1]};
    assign word_done  = (rx_state_reg == ascr_pkg::ASCR_RX_STOP) & rx_tick;
    assign word9      = rx_m_reg ? rx_sh_reg : {1'b0, rx_sh_reg[8:1]};
    assign word_msb   = rx_m_reg ? word9[8] : word9[7];
    assign parity_bad = rx_pce_reg & (par_calc(word9, rx_m_reg) ^ word_msb ^ rx_ps_reg);
    // Muted words are dropped unless wake is on address mark and they carry it
    assign word_take  = word_done & (~ctrl_two[`ASCR_C2_RWU] | (ctrl_one[`ASCR_C1_WAKE] & word_msb));
    assign quiet_hit  = (rx_state_reg == ascr_pkg::ASCR_RX_IDLE) & rx_tick & rx_sync_reg
                        & (quiet_reg == frame_len(ctrl_one[`ASCR_C1_M]) - 4'h1);
    assign mute_clr   = ctrl_two[`ASCR_C2_RWU]
                        & ((word_done & ctrl_one[`ASCR_C1_WAKE] & word_msb)
                        | (quiet_hit & ~ctrl_one[`ASCR_C1_WAKE]));

    always_ff @(posedge sys_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            rx_state_reg <= ascr_pkg::ASCR_RX_IDLE;
            rx_cnt_reg   <= 16'h0000;
            rx_bit_reg   <= 4'h0;
            rx_sh_reg    <= 9'h000;
            rx_m_reg     <= 1'b0;
            rx_pce_reg   <= 1'b0;
            rx_ps_reg    <= 1'b0;
            quiet_reg    <= 4'h0;
        end
        else if (clk_en)
        begin
            if (~ctrl_two[`ASCR_C2_RE])
            begin
                rx_state_reg <= ascr_pkg::ASCR_RX_IDLE;
                rx_cnt_reg   <= 16'h0000;
                quiet_reg    <= 4'h0;
            end
            else
            begin
                unique case (rx_state_reg)
                    ascr_pkg::ASCR_RX_IDLE:
                    begin
                        rx_bit_reg <= 4'h0;
                        if (~rx_sync_reg & rx_prev_reg & ~ctrl_one[`ASCR_C1_OFF])
                        begin
                            rx_state_reg <= ascr_pkg::ASCR_RX_START;
                            rx_cnt_reg   <= 16'h0000;
                            quiet_reg    <= 4'h0;
                            rx_m_reg     <= ctrl_one[`ASCR_C1_M];
                            rx_pce_reg   <= ctrl_one[`ASCR_C1_PCE];
                            rx_ps_reg    <= ctrl_one[`ASCR_C1_PS];
                        end
                        else
                        begin
                            rx_cnt_reg <= rx_tick ? 16'h0000 : rx_cnt_reg + 16'h0001;
                            if (~rx_sync_reg)
                                quiet_reg <= 4'h0;
                            else if (rx_tick & ~quiet_hit & (quiet_reg != 4'hF))
                                quiet_reg <= quiet_reg + 4'h1;
                        end
                    end
                    ascr_pkg::ASCR_RX_START:
                    begin
                        rx_cnt_reg <= rx_half ? 16'h0000 : rx_cnt_reg + 16'h0001;
                        if (rx_half)
                            rx_state_reg <= rx_sync_reg ? ascr_pkg::ASCR_RX_IDLE : ascr_pkg::ASCR_RX_BITS;
                    end
                    ascr_pkg::ASCR_RX_BITS:
                    begin
                        rx_cnt_reg <= rx_tick ? 16'h0000 : rx_cnt_reg + 16'h0001;
                        if (rx_tick)
                        begin
                            rx_sh_reg  <= {rx_sync_reg, rx_sh_reg[8:1]};
                            rx_bit_reg <= rx_bit_reg + 4'h1;
                            if (rx_bit_reg == frame_len(rx_m_reg) - 4'h3)
                                rx_state_reg <= ascr_pkg::ASCR_RX_STOP;
                        end
                    end
                    ascr_pkg::ASCR_RX_STOP:
                    begin
                        rx_cnt_reg <= rx_tick ? 16'h0000 : rx_cnt_reg + 16'h0001;
                        if (rx_tick)
                            rx_state_reg <= ascr_pkg::ASCR_RX_IDLE;
                    end
                endcase
            end
        end
    end

    // Status flags: a hardware set in the same cycle as a software clear wins
    always_ff @(posedge sys_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            tx_holding_empty_reg     <= 1'b1;
            tc_reg       <= 1'b1;
            rx_full_flag_reg     <= 1'b0;
            idle_reg     <= 1'b0;
            ovr_reg      <= 1'b0;
            pe_reg       <= 1'b0;
            rdr_reg      <= 9'h000;
            idle_arm_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (tx_start & ~brk_req_reg & ~pre_req_reg)
                tx_holding_empty_reg <= 1'b1;
            else if (wr_data_seq)
                tx_holding_empty_reg <= 1'b0;
            if (tx_end & (tx_kind_reg == ascr_pkg::ASCR_KIND_DATA))
                tc_reg <= 1'b1;
            else if (wr_data_seq)
                tc_reg <= 1'b0;
            if (word_take & ~rx_full_flag_reg)
            begin
                rx_full_flag_reg <= 1'b1;
                rdr_reg  <= word9; // Overrun keeps the held word intact
            end
            else if (rd_data_seq)
                rx_full_flag_reg <= 1'b0;
            if (word_take & rx_full_flag_reg)
                ovr_reg <= 1'b1;
            else if (rd_data_seq)
                ovr_reg <= 1'b0;
            if (word_take & parity_bad)
                pe_reg <= 1'b1;
            else if (rd_data_seq)
                pe_reg <= 1'b0;
            // Idle is reported once per burst of received data
            if (word_take)
                idle_arm_reg <= 1'b1;
            else if (quiet_hit)
                idle_arm_reg <= 1'b0;
            if (quiet_hit & idle_arm_reg)
                idle_reg <= 1'b1;
            else if (rd_data_seq)
                idle_reg <= 1'b0;
        end
    end

    assign serial_irq = (ctrl_two[`ASCR_C2_TIE] & tx_holding_empty_reg)
                      | (ctrl_two[`ASCR_C2_TX_DONE_IRQ_EN] & tc_reg)
                      | (ctrl_two[`ASCR_C2_RIE] & (ovr_reg | rx_full_flag_reg))
                      | (ctrl_two[`ASCR_C2_LINE_QUIET_IRQ_EN] & idle_reg)
                      | (ctrl_one[`ASCR_C1_PIE] & pe_reg);

endmodule

// >>> src/ascr_defs.svh
// Register map, field positions, reset values and timing for the serial control block
// Operation
// - Nine-bit mode stores the received ninth bit in ctrl_one bit 7.
// - Nine-bit mode transmits ctrl_one bit 6 as the ninth data bit.
// - serial_off stops prescalers and outputs after the byte in progress; the receive bit counter keeps running while rx_on is set.
// - Word length 0 gives 1+8+1 bits, 1 gives 1+9+1 bits.
// - Wake bit 0 wakes on idle line, 1 on address mark.
// - Parity replaces the most significant data bit; received words are checked.
// - Parity enable takes effect from the next word, both directions.
// - odd_even_choice 0 even, 1 odd, applied after the current byte.
// - parity_err_irq_en lets parity errors raise the serial interrupt.
// - ctrl_two resets to zero, disabling everything it controls.
// - tx_empty_irq_en raises the interrupt while tx_holding_empty is set.
// - tx_done_irq_en raises the interrupt while tx_done_flag is set.
// - rx_irq_en raises the interrupt on overrun or rx_full_flag.
// - line_quiet_irq_en raises the interrupt on idle line detected.
// - A zero pulse on tx_on during transmission sends an idle preamble afterwards.
// - Transmission starts one bit time after tx_on is set.
// - Transmit pin is released when tx_on and rx_on clear or never enabled; serial_off also releases it whenever no frame is shifting.
// - Setting rx_on makes the receiver hunt for a start bit.
// - rx_mute mutes the receiver; hardware clears it on wake-up.
// - break_send set then cleared sends one break word after current word.
// - A received word failing parity sets the parity error flag.
// - A word completing while rx_full_flag is set sets the overrun flag.
`ifndef ASCR_DEFS_SVH
`define ASCR_DEFS_SVH

`define ASCR_OFF_CTRL_ONE   5'h00
`define ASCR_OFF_CTRL_TWO   5'h04
`define ASCR_OFF_STATUS     5'h08
`define ASCR_OFF_DATA       5'h0C
`define ASCR_OFF_BAUD       5'h10

`define ASCR_C1_RX9         7
`define ASCR_C1_TX9         6
`define ASCR_C1_OFF         5
`define ASCR_C1_M           4
`define ASCR_C1_WAKE        3
`define ASCR_C1_PCE         2
`define ASCR_C1_PS          1
`define ASCR_C1_PIE         0

`define ASCR_C2_TIE         7
`define ASCR_C2_TX_DONE_IRQ_EN        6
`define ASCR_C2_RIE         5
`define ASCR_C2_LINE_QUIET_IRQ_EN        4
`define ASCR_C2_TE          3
`define ASCR_C2_RE          2
`define ASCR_C2_RWU         1
`define ASCR_C2_SBK         0

`define ASCR_CTRL_ONE_RST   8'h00
`define ASCR_CTRL_TWO_RST   8'h00
`define ASCR_BAUD_RST       16'h015B

`define ASCR_LEN_EIGHT      4'hA
`define ASCR_LEN_NINE       4'hB

`endif

// >>> src/ascr_pkg.sv
// Types shared by the serial control block
package ascr_pkg;

    typedef enum logic [1:0] {
        ASCR_TX_IDLE  = 2'b00,
        ASCR_TX_WAIT  = 2'b01,
        ASCR_TX_SHIFT = 2'b10
    } ascr_tx_state_e;

    typedef enum logic [1:0] {
        ASCR_RX_IDLE  = 2'b00,
        ASCR_RX_START = 2'b01,
        ASCR_RX_BITS  = 2'b10,
        ASCR_RX_STOP  = 2'b11
    } ascr_rx_state_e;

    typedef enum logic [1:0] {
        ASCR_KIND_DATA  = 2'b00,
        ASCR_KIND_BREAK = 2'b01,
        ASCR_KIND_IDLE  = 2'b10
    } ascr_kind_e;

endpackage

// >>> verif/ascr_core_props.sv
// Port checker for the serial control block
`timescale 1ns/10ps
module ascr_core_props (
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        tx_out,
    input wire logic        tx_oe,
    input wire logic        serial_irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    logic [7:0] sh2;
    logic       parity_err_irq_en;
    logic       ever;
    wire        wr_c = avs_write && !avs_waitrequest;
    wire        rd_c = avs_read && !avs_waitrequest;
    // Mute bit is left out of the readback check: hardware may clear it
    always_ff @(posedge sys_clk or negedge nrst)
        if (!nrst)
            {sh2, parity_err_irq_en, ever} <= 10'h000;
        else if (wr_c && avs_address == 5'h04)
            {sh2, ever} <= {avs_writedata[7:0], ever | avs_writedata[3]};
        else if (wr_c && avs_address == 5'h00)
            parity_err_irq_en <= avs_writedata[0];
    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    unmapped_zero_a: assert property (rd_c && avs_address == 5'h14 |-> avs_readdata == 32'h00000000)
        else $error("unmapped read not zero");
    reg_back_a: assert property (rd_c && avs_address == 5'h04 |-> avs_readdata == {24'h000000, sh2[7:2], avs_readdata[1], sh2[0]})
        else $error("ctrl_two readback wrong");
    reset_quiet_a: assert property ($rose(nrst) |-> (!serial_irq && !tx_oe)[*3])
        else $error("active after reset");
    irq_two_a: assert property (wr_c && avs_address == 5'h04 && avs_writedata[7:4] == 4'h0 && !parity_err_irq_en |=> !serial_irq)
        else $error("irq while masked");
    irq_pie_a: assert property (wr_c && avs_address == 5'h00 && !avs_writedata[0] && sh2[7:4] == 4'h0 |=> !serial_irq)
        else $error("parity irq while masked");
    oe_never_a: assert property (tx_oe |-> ever)
        else $error("pin driven before enable");
    idle_high_a: assert property (!tx_oe |-> tx_out)
        else $error("released pin not idle");
    tx_delay_a: assert property ($rose(sh2[3]) && !$past(tx_oe) |-> tx_out[*8])
        else $error("no bit time wait");
    start_bit_a: assert property ($fell(tx_out) |-> !tx_out[*8])
        else $error("bit shorter than minimum");
    cover property (wr_c && avs_address == 5'h0C);
    cover property ($fell(tx_out));
    cover property ($rose(serial_irq));
endmodule
bind ascr_core ascr_core_props u_props (.*);

// >>> verif/ascr_core_test.sv
// Self-checking bench for the serial control block
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module ascr_core_test;
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic        rd_s = 1'b0;
    logic        wr_s = 1'b0;
    logic [31:0] wd = 32'h00000000;
    logic [31:0] rdat;
    logic [31:0] v;
    logic        wq;
    logic        rx_in;
    logic        tx_out;
    logic        irq;
    int          miscompares = 0;
    int          n_tests = 0;
    ascr_node #(.BAUD(16)) node (.sys_clk(sys_clk), .tx_out(tx_out), .rx_in(rx_in));
    ascr_core dut (.sys_clk(sys_clk), .nrst(nrst), .clk_en(1'b1), .avs_address(adr), .avs_read(rd_s),
        .avs_write(wr_s), .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wq),
        .rx_in(rx_in), .tx_out(tx_out), .tx_oe(), .serial_irq(irq));
    initial forever #12.5 sys_clk = ~sys_clk;
    task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d);
        @(posedge sys_clk);
        adr <= a;
        wd <= {24'h000000, d};
        wr_s <= w;
        rd_s <= !w;
        do @(posedge sys_clk); while (wq);
        v = rdat;
        wr_s <= 1'b0;
        rd_s <= 1'b0;
        @(negedge sys_clk);
    endtask
    // Extra bit time lets the stop bit end before any format change
    task automatic frame(input logic [10:0] e);
        int n;
        n = node.nfr;
        repeat (400) if (node.nfr == n) @(posedge sys_clk);
        `CHK(node.got, e)
        repeat (16) @(posedge sys_clk);
    endtask
    task automatic tx(input logic [7:0] d, input logic [10:0] e);
        bus(5'h08, 1'b0, 8'h00);
        bus(5'h0C, 1'b1, d);
        frame(e);
    endtask
    initial
    begin
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        bus(5'h04, 1'b0, 8'h00);
        `CHK(v, 32'h00000000)
        bus(5'h14, 1'b0, 8'h00);
        `CHK(v, 32'h00000000)
        bus(5'h10, 1'b1, 8'h10);
        bus(5'h04, 1'b1, 8'h8C);
        `CHK(irq, 1'b1)
        bus(5'h04, 1'b1, 8'h0C);
        `CHK(irq, 1'b0)
        bus(5'h00, 1'b1, 8'h06);
        tx(8'h01, 11'h202);
        bus(5'h00, 1'b1, 8'h50);
        node.len = 11;
        tx(8'hA5, 11'h74A);
        bus(5'h04, 1'b1, 8'h0D);
        bus(5'h04, 1'b1, 8'h0C);
        frame(11'h000);
        node.send({2'b11, 8'h3C, 1'b0}, 11);
        bus(5'h08, 1'b0, 8'h00);
        `CHK(v[5], 1'b1)
        bus(5'h00, 1'b0, 8'h00);
        `CHK(v[7], 1'b1)
        bus(5'h0C, 1'b0, 8'h00);
        `CHK(v[7:0], 8'h3C)
        bus(5'h00, 1'b1, 8'h05);
        node.send({2'b11, 8'h01, 1'b0}, 10);
        `CHK(irq, 1'b1)
        bus(5'h08, 1'b0, 8'h00);
        `CHK(v[0], 1'b1)
        bus(5'h00, 1'b1, 8'h04);
        `CHK(irq, 1'b0)
        bus(5'h04, 1'b1, 8'h1E);
        repeat (200) @(posedge sys_clk);
        bus(5'h04, 1'b0, 8'h00);
        `CHK(v, 32'h0000001C)
        `CHK(irq, 1'b1)
        node.send({2'b11, 8'h02, 1'b0}, 10);
        bus(5'h08, 1'b0, 8'h00);
        `CHK(v[3], 1'b1)
        summarize;
    end
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        summarize;
    end
    task automatic summarize;
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
endmodule

// >>> verif/ascr_node.sv
// Remote serial node on the transmit and receive pins
`timescale 1ns/10ps
module ascr_node #(parameter int BAUD = 16) (
    input  wire logic sys_clk,
    input  wire logic tx_out,
    output logic      rx_in
);
    logic [10:0] got = 11'h000;
    int          len = 10;
    int          nfr = 0;
    initial rx_in = 1'b1;
    // Mid-bit sampling tolerates a cycle or two of edge skew
    initial forever
    begin
        @(posedge sys_clk iff tx_out);
        @(posedge sys_clk iff !tx_out);
        repeat (BAUD / 2) @(posedge sys_clk);
        for (int i = 0; i < len; i++)
        begin
            got[i] = tx_out;
            if (i < len - 1)
                repeat (BAUD) @(posedge sys_clk);
        end
        nfr++;
    end
    task automatic send(input logic [10:0] f, input int n);
        for (int i = 0; i < n; i++)
            repeat (BAUD) @(posedge sys_clk) rx_in <= f[i];
    endtask
endmodule
